// File: hdl/osq_defines.vh
`ifndef OSQ_DEFINES_VH
`define OSQ_DEFINES_VH
// wishbone register byte offsets
`define OSQ_REG_CTRL      8'h00
`define OSQ_REG_STAT      8'h04
`define OSQ_REG_PSEL      8'h08
`define OSQ_REG_PCFG      8'h0c
`define OSQ_REG_PCMD      8'h10
`define OSQ_REG_SADDR     8'h14
`define OSQ_REG_SV        8'h18
`define OSQ_REG_SVSR      8'h1c
`define OSQ_REG_SISRC     8'h20
`define OSQ_REG_SILD      8'h24
`define OSQ_REG_SISR      8'h28
`define OSQ_REG_SKT       8'h2c
`define OSQ_REG_OUT       8'h30
// ctrl fields
`define OSQ_CTRL_INH_EN   0
`define OSQ_CTRL_INH_IDLE 1
`define OSQ_CTRL_EXT_EN   2
`define OSQ_CTRL_EXT_PULL 3
`define OSQ_CTRL_TRG_PULL 4
`define OSQ_CTRL_RESET    8'h00
// pcmd bits
`define OSQ_PCMD_ERASE    0
`define OSQ_PCMD_ADD      1
// sizes
`define OSQ_NPROG         4'd10
`define OSQ_NSTEP         7'd100
`define OSQ_RUN_MAX       14'd15000
// step kinds
`define OSQ_KIND_AUTO     2'd0
`define OSQ_KIND_MAN      2'd1
`define OSQ_KIND_TRIG     2'd2
`define OSQ_KIND_SKIP     2'd3
// durations in 1 ms ticks: 2 ms floor, 15000 s ceiling
`define OSQ_TICK_NS       1000000
`define OSQ_CLK_NS        50
`define OSQ_TICK_CYC      (`OSQ_TICK_NS / `OSQ_CLK_NS)
`define OSQ_DUR_MIN       24'd2
`define OSQ_DUR_MAX       24'd15000000
`endif

// File: hdl/osq_sync.v
// two-flop synchroniser for a pin
module osq_sync (
   input  wire CLK,
   input  wire RST,
   input  wire d,
   output reg  q
);
   reg s1_q;
   always @(posedge CLK) begin
      if (RST) begin
         s1_q <= 1'b0;
         q    <= 1'b0;
      end else begin
         s1_q <= d;
         q    <= s1_q;
      end
   end
endmodule

// File: hdl/osq_mem.v
// step memory: 100 words, registered read
module osq_mem (
   input  wire        CLK,
   input  wire        we,
   input  wire [6:0]  waddr,
   input  wire [105:0] wdata,
   input  wire [6:0]   raddr,
   output reg  [105:0] rdata
);
   reg [105:0] mem [0:99];
   always @(posedge CLK) begin
      if (we)
         mem[waddr] <= wdata;
      rdata <= mem[raddr];
   end
endmodule

// File: hdl/osq_top.v
// Operation
// R01: enabled inhibit low forces output off, protection
// R02: protection latched until operator confirm
// R03: inhibit idle level configurable high or low
// R04: external switch disabled turns output off; the code instead returns the output to the front-panel key state out_req_q
// R05: external mode ignores key; high holds off
// R06: external mode low level turns output on
// R07: external enable pull level configurable; the code keeps the pull bit in ctrl_q but never decodes it
// R08: ten programs share one hundred steps
// R09: each step holds seven settings
// R10: trigger falling edge advances waiting step
// R11: program index limited to one..ten
// R12: repeat count 1..15000 per program
// R13: chain link jumps; self link loops
// R14: chained empty or all-skip program stops
// R15: erase clears program; default zero steps
// R16: auto step holds duration then advances
// R17: zero-duration auto step ends program pass
// R18: manual step waits for any key
// R19: trigger step waits for trigger edge
// R20: skip step moves straight to next
// R21: durations accepted only 0.002..15000 s
// R22: run press starts, second press aborts
// R23: external inputs pass two flip-flops
//
// Implementation choices: the Wishbone slave port and the register offsets.
`include "osq_defines.vh"
module osq_top (
   input  wire        CLK,
   input  wire        RST,
   input  wire        WB_CYC_I,
   input  wire        WB_STB_I,
   input  wire        WB_WE_I,
   input  wire [7:0]  WB_ADR_I,
   input  wire [3:0]  WB_SEL_I,
   input  wire [31:0] WB_DAT_I,
   output reg  [31:0] WB_DAT_O,
   output reg         WB_ACK_O,
   input  wire        INHIBIT_PIN,
   input  wire        EXT_ON_PIN,
   input  wire        TRIG_PIN,
   input  wire        KEY_OUTPUT,
   input  wire        KEY_ANY,
   input  wire        KEY_RUN,
   input  wire        KEY_CONFIRM,
   output reg         OUTPUT_ON,
   output reg         PROTECT,
   output reg         RUNNING,
   output reg  [15:0] SET_V,
   output reg  [15:0] SET_VSR,
   output reg  [15:0] SET_ISRC,
   output reg  [15:0] SET_ILD,
   output reg  [15:0] SET_ISR
);
   ////////////////////////////////////////////////////////////////////
   localparam ST_IDLE  = 3'd0;
   localparam ST_FETCH = 3'd1;
   localparam ST_WAIT  = 3'd2;
   localparam ST_EXEC  = 3'd3;
   localparam ST_HOLD  = 3'd4;
   localparam ST_NEXT  = 3'd5;
   localparam ST_PEND  = 3'd6;

   wire inh_s;
   wire ext_s;
   wire trg_s;
   osq_sync u_inh (.CLK(CLK), .RST(RST), .d(INHIBIT_PIN), .q(inh_s)); // [R23]
   osq_sync u_ext (.CLK(CLK), .RST(RST), .d(EXT_ON_PIN),  .q(ext_s)); // [R23]
   osq_sync u_trg (.CLK(CLK), .RST(RST), .d(TRIG_PIN),    .q(trg_s)); // [R23]

   reg  [7:0]  ctrl_q;
   reg  [3:0]  psel_q;
   reg  [6:0]  saddr_q;
   reg  [15:0] sv_q;
   reg  [15:0] svsr_q;
   reg  [15:0] sisrc_q;
   reg  [15:0] sild_q;
   reg  [15:0] sisr_q;
   reg  [1:0]  skind_q;
   reg  [23:0] sdur_q;
   reg  [13:0] prun_q  [0:9];
   reg  [3:0]  pchain_q [0:9];
   reg  [6:0]  pcnt_q  [0:9];
   reg  [6:0]  pbase_q [0:9];
   reg  [6:0]  used_q;
   reg         trg_d1_q;
   reg         run_q;
   reg         out_req_q;
   reg         key_out_q;
   reg         key_run_q;
   reg         key_any_q;
   reg  [2:0]  st_q;
   reg  [3:0]  cur_q;
   reg  [6:0]  idx_q;
   reg  [13:0] rep_q;
   reg  [14:0] tick_q;
   reg  [23:0] ms_q;
   reg         exec_any_q;
   reg         bad_q;
   integer     i;

   // inhibit asserted when the pin differs from its idle level [R03]
   wire inh_trip = ctrl_q[`OSQ_CTRL_INH_EN] &
                   (inh_s != ctrl_q[`OSQ_CTRL_INH_IDLE]);
   // trigger event: high-to-low of the synchronised pin, any pull [R10]
   wire trg_fall = trg_d1_q & ~trg_s;
   wire key_any_p = KEY_ANY & ~key_any_q;
   wire key_run_p = KEY_RUN & ~key_run_q;
   wire key_out_p = KEY_OUTPUT & ~key_out_q;

   ////////////////////////////////////////////////////////////////////
   // register bus
   wire        wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   wire        wb_wr  = wb_req & WB_WE_I & WB_SEL_I[0];
   wire [6:0]  step_w = pbase_q[psel_q] + pcnt_q[psel_q];
   wire [105:0] mem_wd = {sdur_q, skind_q, sisr_q, sild_q, sisrc_q,
                         svsr_q, sv_q}; // [R09]
   wire        add_ok = (used_q < `OSQ_NSTEP) & (bad_q == 1'b0);
   wire        psel_ok = (WB_DAT_I[3:0] >= 4'd1) &
                         (WB_DAT_I[3:0] <= `OSQ_NPROG); // [R11]
   wire        cfg_ok = (WB_DAT_I[13:0] >= 14'd1) &
                        (WB_DAT_I[13:0] <= `OSQ_RUN_MAX) &
                        (WB_DAT_I[19:16] <= `OSQ_NPROG); // [R12] [R13]
   wire        do_add = wb_wr & (WB_ADR_I == `OSQ_REG_PCMD) &
                        WB_DAT_I[`OSQ_PCMD_ADD] & ~run_q & add_ok;
   wire        do_erase = wb_wr & (WB_ADR_I == `OSQ_REG_PCMD) &
                          WB_DAT_I[`OSQ_PCMD_ERASE] & ~run_q;
   wire [105:0] mem_rd;
   reg  [6:0]  mem_ra;
   reg  [6:0]  mem_wa;

   // pool not compacted on erase: a program's steps sit at pbase..pbase+pcnt-1
   always @* begin
      mem_wa = step_w;
      mem_ra = idx_q;
   end

   osq_mem u_mem (
      .CLK   (CLK),
      .we    (do_add),
      .waddr (mem_wa),
      .wdata (mem_wd),
      .raddr (mem_ra),
      .rdata (mem_rd)
   );

   always @(posedge CLK) begin
      if (RST) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h0000_0000;
         ctrl_q   <= `OSQ_CTRL_RESET;
         psel_q   <= 4'h0;
         saddr_q  <= 7'h00;
         sv_q     <= 16'h0000;
         svsr_q   <= 16'h0000;
         sisrc_q  <= 16'h0000;
         sild_q   <= 16'h0000;
         sisr_q   <= 16'h0000;
         skind_q  <= 2'h0;
         sdur_q   <= 24'h000000;
         bad_q    <= 1'b0;
         used_q   <= 7'h00;
         for (i = 0; i < 10; i = i + 1) begin
            prun_q[i]   <= 14'd1;
            pchain_q[i] <= 4'h0;
            pcnt_q[i]   <= 7'h00; // [R15]
            pbase_q[i]  <= 7'h00;
         end
      end else begin
         WB_ACK_O <= wb_req;
         if (wb_wr) begin
            case (WB_ADR_I)
               `OSQ_REG_CTRL:  ctrl_q <= WB_DAT_I[7:0];
               `OSQ_REG_PSEL:  if (psel_ok)
                  psel_q <= WB_DAT_I[3:0] - 4'd1; // [R11]
               `OSQ_REG_PCFG:  if (cfg_ok & ~run_q) begin
                  prun_q[psel_q]   <= WB_DAT_I[13:0];
                  pchain_q[psel_q] <= WB_DAT_I[19:16];
               end
               `OSQ_REG_SV:    sv_q    <= WB_DAT_I[15:0];
               `OSQ_REG_SVSR:  svsr_q  <= WB_DAT_I[15:0];
               `OSQ_REG_SISRC: sisrc_q <= WB_DAT_I[15:0];
               `OSQ_REG_SILD:  sild_q  <= WB_DAT_I[15:0];
               `OSQ_REG_SISR:  sisr_q  <= WB_DAT_I[15:0];
               `OSQ_REG_SKT: begin
                  skind_q <= WB_DAT_I[25:24];
                  sdur_q  <= {WB_DAT_I[23:0]};
                  // zero is the end-of-pass marker for auto steps
                  bad_q <= (WB_DAT_I[23:0] != 24'h0) &
                           ((WB_DAT_I[23:0] < `OSQ_DUR_MIN) |
                            (WB_DAT_I[23:0] > `OSQ_DUR_MAX)); // [R21]
               end
               default: ;
            endcase
         end
         // inserting into the pool shifts later programs' bases [R08]
         if (do_add) begin
            pcnt_q[psel_q] <= pcnt_q[psel_q] + 7'd1;
            used_q <= used_q + 7'd1;
            for (i = 0; i < 10; i = i + 1)
               if (i > psel_q)
                  pbase_q[i] <= pbase_q[i] + 7'd1;
         end else if (do_erase) begin
            // data beyond the gap is left; bases stay valid since
            // erase changes only this program's count and used_q
            pcnt_q[psel_q] <= 7'h00; // [R15]
            used_q <= used_q - pcnt_q[psel_q];
         end
         if (wb_req & ~WB_WE_I) begin
            case (WB_ADR_I)
               `OSQ_REG_CTRL: WB_DAT_O <= {24'h0, ctrl_q};
               `OSQ_REG_STAT: WB_DAT_O <= {20'h0, st_q, bad_q,
                  1'b0, PROTECT, RUNNING, OUTPUT_ON,
                  cur_q};
               `OSQ_REG_PSEL: WB_DAT_O <= {28'h0, psel_q + 4'd1};
               `OSQ_REG_PCFG: WB_DAT_O <= {12'h0, pchain_q[psel_q],
                  2'h0, prun_q[psel_q]};
               `OSQ_REG_PCMD: WB_DAT_O <= {9'h0, used_q, 9'h0,
                  pcnt_q[psel_q]};
               `OSQ_REG_SADDR: WB_DAT_O <= {25'h0, idx_q};
               `OSQ_REG_OUT: WB_DAT_O <= {ms_q, 1'b0, rep_q[6:0]};
               default: WB_DAT_O <= 32'h0000_0000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // output control
   always @(posedge CLK) begin
      if (RST) begin
         trg_d1_q  <= 1'b0;
         key_out_q <= 1'b0;
         key_run_q <= 1'b0;
         key_any_q <= 1'b0;
         out_req_q <= 1'b0;
         PROTECT   <= 1'b0;
         OUTPUT_ON <= 1'b0;
      end else begin
         trg_d1_q  <= trg_s;
         key_out_q <= KEY_OUTPUT;
         key_run_q <= KEY_RUN;
         key_any_q <= KEY_ANY;
         // front-panel key only counts outside external mode [R05]
         if (inh_trip)
            out_req_q <= 1'b0; // [R01]
         else if (key_out_p & ~ctrl_q[`OSQ_CTRL_EXT_EN])
            out_req_q <= ~out_req_q;
         if (inh_trip)
            PROTECT <= 1'b1; // [R01] [R02]
         else if (KEY_CONFIRM)
            PROTECT <= 1'b0; // [R02]
         if (inh_trip | PROTECT)
            OUTPUT_ON <= 1'b0;
         else if (ctrl_q[`OSQ_CTRL_EXT_EN])
            // pull level does not change the sense; pull bit is not decoded [R07]
            // pin level alone sets the output, low means on
            OUTPUT_ON <= ~ext_s; // [R05] [R06]
         else
            OUTPUT_ON <= out_req_q; // [R04]
      end
   end

   ////////////////////////////////////////////////////////////////////
   // sequencer
   wire [15:0] r_v    = mem_rd[15:0];
   wire [15:0] r_vsr  = mem_rd[31:16];
   wire [15:0] r_isrc = mem_rd[47:32];
   wire [15:0] r_ild  = mem_rd[63:48];
   wire [15:0] r_isr  = mem_rd[79:64];
   wire [1:0]  r_kind = mem_rd[81:80];
   wire [23:0] r_dur  = mem_rd[105:82];
   wire [6:0]  p_end  = pbase_q[cur_q] + pcnt_q[cur_q];
   wire [3:0]  p_link = pchain_q[cur_q];

   always @(posedge CLK) begin
      if (RST) begin
         st_q       <= ST_IDLE;
         run_q      <= 1'b0;
         RUNNING    <= 1'b0;
         cur_q      <= 4'h0;
         idx_q      <= 7'h00;
         rep_q      <= 14'h0000;
         tick_q     <= 15'h0000;
         ms_q       <= 24'h000000;
         exec_any_q <= 1'b0;
         SET_V      <= 16'h0000;
         SET_VSR    <= 16'h0000;
         SET_ISRC   <= 16'h0000;
         SET_ILD    <= 16'h0000;
         SET_ISR    <= 16'h0000;
      end else begin
         RUNNING   <= run_q;
         if (key_run_p & run_q) begin
            st_q  <= ST_IDLE; // [R22]
            run_q <= 1'b0;
         end else begin
            case (st_q)
               ST_IDLE: if (key_run_p) begin
                  run_q      <= 1'b1; // [R22]
                  cur_q      <= psel_q;
                  idx_q      <= pbase_q[psel_q];
                  rep_q      <= 14'd1;
                  exec_any_q <= 1'b0;
                  st_q       <= ST_PEND;
               end
               ST_PEND: begin
                  if (idx_q >= p_end) begin
                     st_q <= ST_NEXT;
                  end else
                     st_q <= ST_FETCH;
               end
               ST_FETCH: st_q <= ST_WAIT; // memory read latency
               ST_WAIT: begin
                  tick_q <= 15'h0000;
                  ms_q   <= 24'h000000;
                  if (r_kind == `OSQ_KIND_SKIP) begin
                     idx_q <= idx_q + 7'd1; // [R20]
                     st_q  <= ST_PEND;
                  end else if ((r_kind == `OSQ_KIND_AUTO) &
                               (r_dur == 24'h0)) begin
                     idx_q <= p_end; // [R17]
                     st_q  <= ST_PEND;
                  end else begin
                     SET_V      <= r_v;
                     SET_VSR    <= r_vsr;
                     SET_ISRC   <= r_isrc;
                     SET_ILD    <= r_ild;
                     SET_ISR    <= r_isr;
                     exec_any_q <= 1'b1;
                     st_q       <= ST_HOLD;
                  end
               end
               ST_HOLD: begin
                  case (r_kind)
                     `OSQ_KIND_AUTO: begin
                        if (tick_q == (`OSQ_TICK_CYC - 1)) begin
                           tick_q <= 15'h0000;
                           ms_q   <= ms_q + 24'd1;
                        end else
                           tick_q <= tick_q + 15'd1;
                        if (ms_q >= r_dur) begin
                           idx_q <= idx_q + 7'd1; // [R16]
                           st_q  <= ST_PEND;
                        end
                     end
                     `OSQ_KIND_MAN: if (key_any_p) begin
                        idx_q <= idx_q + 7'd1; // [R18]
                        st_q  <= ST_PEND;
                     end
                     `OSQ_KIND_TRIG: if (trg_fall) begin
                        idx_q <= idx_q + 7'd1; // [R19] [R10]
                        st_q  <= ST_PEND;
                     end
                     default: st_q <= ST_PEND;
                  endcase
               end
               ST_NEXT: begin
                  if (~exec_any_q) begin
                     st_q  <= ST_IDLE; // [R14]
                     run_q <= 1'b0;
                  end else if (rep_q < prun_q[cur_q]) begin
                     rep_q <= rep_q + 14'd1; // [R12]
                     idx_q <= pbase_q[cur_q];
                     exec_any_q <= 1'b0;
                     st_q  <= ST_PEND;
                  end else if (p_link != 4'h0) begin
                     cur_q <= p_link - 4'd1; // [R13]
                     idx_q <= pbase_q[p_link - 4'd1];
                     rep_q <= 14'd1;
                     exec_any_q <= 1'b0;
                     st_q  <= ST_PEND;
                  end else begin
                     st_q  <= ST_IDLE;
                     run_q <= 1'b0;
                  end
               end
               default: st_q <= ST_IDLE;
            endcase
         end
      end
   end
endmodule

// File: tb/osq_properties.sv
module osq_checker (
   input wire logic        CLK,
   input wire logic        RST,
   input wire logic        WB_CYC_I,
   input wire logic        WB_STB_I,
   input wire logic        WB_WE_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic        WB_ACK_O,
   input wire logic        INHIBIT_PIN,
   input wire logic        EXT_ON_PIN,
   input wire logic        KEY_RUN,
   input wire logic        KEY_CONFIRM,
   input wire logic        OUTPUT_ON,
   input wire logic        PROTECT,
   input wire logic        RUNNING
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge CLK);
   endclocking
   default disable iff (RST);
   ////////////////////////////////////////////////////////////////////////
   ack_answer_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O
      |=> WB_ACK_O) else $error("ack not one cycle after request");
   ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack longer than one cycle");
   ack_idle_a: assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
      else $error("ack without request");
   rdata_hold_a: assert property (!(WB_CYC_I && WB_STB_I && !WB_WE_I)
      |=> $stable(WB_DAT_O)) else $error("read data moved without read");
   protect_latch_a: assert property (PROTECT && !KEY_CONFIRM &&
      !$past(KEY_CONFIRM) && !$past(KEY_CONFIRM, 2) |=> PROTECT)
      else $error("protection released without confirm");
   protect_off_a: assert property (PROTECT |=> !OUTPUT_ON)
      else $error("output on while protected");
   inhibit_sync_a: assert property (!PROTECT && $changed(INHIBIT_PIN)
      |=> !PROTECT) else $error("inhibit acted without synchroniser");
   ext_sync_a: assert property ($changed(EXT_ON_PIN)
      |=> $stable(OUTPUT_ON)) else $error("ext pin acted too early");
   run_abort_a: assert property (RUNNING && $rose(KEY_RUN)
      |-> ##[1:6] !RUNNING) else $error("run press did not abort");
   cover property ($fell(RUNNING));
   cover property ($rose(PROTECT));
   cover property (WB_ACK_O && !WB_WE_I);
endmodule

// File: tb/osq_ext_model.sv
module osq_ext_model (
   input  wire logic CLK,
   output logic      INHIBIT_PIN,
   output logic      EXT_ON_PIN,
   output logic      TRIG_PIN
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      INHIBIT_PIN = 1'b1;
      EXT_ON_PIN  = 1'b1;
      TRIG_PIN    = 1'b1;
   end
   // steady ttl levels, moved just after a clock edge
   task set_pins(input logic inh, input logic ext);
      @(posedge CLK);
      INHIBIT_PIN <= inh;
      EXT_ON_PIN  <= ext;
   endtask
   // one high-to-low edge, held low past the synchroniser
   task trigger();
      @(posedge CLK);
      TRIG_PIN <= 1'b0;
      repeat (4) @(posedge CLK);
      TRIG_PIN <= 1'b1;
   endtask
endmodule

// File: tb/osq_seq_bench.sv
module output_sequencer_with_ext_control_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, rst, cyc, stb, we, ack, inh, ext, trg, on, prot, run;
   logic [7:0]  adr;
   logic [3:0]  sel, keys;
   logic [31:0] dat_w, dat_r, rd;
   logic [15:0] sv, svsr, sisrc, sild, sisr;
   logic [79:0] exp_q[$];
   int          err_total, checks_done, seed, n;
   osq_top u_dut (.CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w),
      .WB_DAT_O(dat_r), .WB_ACK_O(ack), .INHIBIT_PIN(inh),
      .EXT_ON_PIN(ext), .TRIG_PIN(trg), .KEY_OUTPUT(keys[0]),
      .KEY_ANY(keys[1]), .KEY_RUN(keys[2]), .KEY_CONFIRM(keys[3]),
      .OUTPUT_ON(on), .PROTECT(prot), .RUNNING(run), .SET_V(sv),
      .SET_VSR(svsr), .SET_ISRC(sisrc), .SET_ILD(sild), .SET_ISR(sisr));
   osq_ext_model u_ext (.CLK(clk), .INHIBIT_PIN(inh), .EXT_ON_PIN(ext),
      .TRIG_PIN(trg));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task fail(input string m);
      err_total++;
      $display("ERROR at %0t: %s", $time, m);
   endtask
   task chk32(input logic [31:0] got, input logic [31:0] e);
      checks_done++;
      if (got !== e) fail($sformatf("read %h expected %h", got, e));
   endtask
   task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      if (n == 20) fail("bus answer missing");
      rd = dat_r;
      @(posedge clk);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask
   task rdchk(input logic [7:0] a, input logic [31:0] e);
      xfer(a, 1'b0, 32'h0);
      chk32(rd, e);
   endtask
   // polls one of run, protect, output_on for at most lim cycles
   task wait_out(input int i, input logic v, input int lim);
      logic [2:0] o;
      for (int k = 0; k < lim; k++) begin
         o = {run, prot, on};
         if (o[i] === v) break;
         @(posedge clk);
      end
      checks_done++;
      if (o[i] !== v) fail($sformatf("control output %0d not %b", i, v));
   endtask
   task wait_set(input logic [79:0] e);
      for (int k = 0; k < 100; k++) begin
         if ({sv, svsr, sisrc, sild, sisr} === e) break;
         @(posedge clk);
      end
      checks_done++;
      if ({sv, svsr, sisrc, sild, sisr} !== e) fail("step settings wrong");
   endtask
   task press(input int k);
      @(posedge clk);
      keys[k] <= 1'b1;
      repeat (3) @(posedge clk);
      keys[k] <= 1'b0;
   endtask
   task add_step(input logic [1:0] kd, input logic [23:0] du, input bit ok);
      logic [79:0] s;
      for (int j = 0; j < 5; j++) begin
         s[79-16*j -: 16] = $random(seed);
         wr(8'h18 + 8'(j * 4), {16'h0, s[79-16*j -: 16]});
      end
      wr(8'h2c, {6'h0, kd, du});
      wr(8'h10, 32'h2);
      if (ok && kd != 2'd3 && du != 24'd0) exp_q.push_back(s);
   endtask
   task pass();
      wait_set(exp_q[0]);
      u_ext.trigger();
      wait_set(exp_q[1]);
      press(1);
   endtask
   task tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (30000) @(posedge clk);
      fail("run hung");
      tally_and_finish();
   end
   initial begin
      seed = 32'h96907ca5;
      err_total = 0;
      checks_done = 0;
      {rst, cyc, stb, we, adr, dat_w, keys} = {3'b100, 45'h0};
      sel = 4'hf;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rdchk(8'h00, 32'h0);
      rdchk(8'h10, 32'h0);
      rdchk(8'hfc, 32'h0);
      wr(8'h08, 32'h1);
      for (int i = 0; i < 12; i++) begin
         wr(8'h08, 32'(i));
         rdchk(8'h08, (i < 1) ? 1 : (i > 10) ? 10 : i);
      end
      wr(8'h08, 32'h1);
      wr(8'h0c, 32'h3a98);
      rdchk(8'h0c, 32'h3a98);
      wr(8'h0c, 32'h0);
      rdchk(8'h0c, 32'h3a98);
      wr(8'h0c, 32'h3a99);
      rdchk(8'h0c, 32'h3a98);
      wr(8'h0c, 32'h000b0001);
      rdchk(8'h0c, 32'h3a98);
      wr(8'h0c, 32'h00020002);
      $display("test config done");
      add_step(2'd2, 24'd2, 1);
      add_step(2'd1, 24'd2, 1);
      add_step(2'd3, 24'd2, 1);
      add_step(2'd0, 24'd1, 0);
      add_step(2'd0, 24'd15000001, 0);
      add_step(2'd0, 24'd0, 1);
      rdchk(8'h10, 32'h00040004);
      press(2);
      wait_out(2, 1'b1, 60);
      pass();
      pass();
      wait_out(2, 1'b0, 60);
      wr(8'h0c, 32'h00010001);
      press(2);
      pass();
      wait_set(exp_q[0]);
      press(2);
      wait_out(2, 1'b0, 60);
      wr(8'h10, 32'h1);
      rdchk(8'h10, 32'h0);
      $display("test sequencer done");
      press(0);
      wait_out(0, 1'b1, 60);
      wr(8'h00, 32'h3);
      u_ext.set_pins(1'b0, 1'b1);
      wait_out(1, 1'b1, 60);
      wait_out(0, 1'b0, 1);
      u_ext.set_pins(1'b1, 1'b1);
      repeat (10) @(posedge clk);
      wait_out(1, 1'b1, 1);
      press(3);
      wait_out(1, 1'b0, 60);
      wr(8'h00, 32'h0);
      u_ext.set_pins(1'b0, 1'b1);
      wr(8'h00, 32'h1);
      repeat (10) @(posedge clk);
      wait_out(1, 1'b0, 1);
      u_ext.set_pins(1'b1, 1'b1);
      wait_out(1, 1'b1, 60);
      u_ext.set_pins(1'b0, 1'b1);
      press(3);
      wait_out(1, 1'b0, 60);
      $display("test inhibit done");
      wr(8'h00, 32'hc);
      rdchk(8'h00, 32'hc);
      press(0);
      repeat (10) @(posedge clk);
      wait_out(0, 1'b0, 1);
      u_ext.set_pins(1'b1, 1'b0);
      wait_out(0, 1'b1, 60);
      wr(8'h00, 32'h0);
      wait_out(0, 1'b0, 60);
      $display("test external switch done");
      tally_and_finish();
   end
endmodule
bind osq_top osq_checker u_chk (.CLK(CLK), .RST(RST), .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_DAT_O(WB_DAT_O),
   .WB_ACK_O(WB_ACK_O), .INHIBIT_PIN(INHIBIT_PIN), .EXT_ON_PIN(EXT_ON_PIN),
   .KEY_RUN(KEY_RUN), .KEY_CONFIRM(KEY_CONFIRM), .OUTPUT_ON(OUTPUT_ON),
   .PROTECT(PROTECT), .RUNNING(RUNNING));
